// file: rtl/mcsi_consts.vh
// constants for the module configuration and status indicator block
`ifndef MCSI_CONSTS_VH
`define MCSI_CONSTS_VH

// ahb register byte addresses
`define MCSI_A_CFG 12'h000
`define MCSI_A_CTRL 12'h004
`define MCSI_A_STAT 12'h008
`define MCSI_A_IRQ_STAT 12'h00C
`define MCSI_A_IRQ_CLR 12'h010
`define MCSI_A_IRQ_EN 12'h014
`define MCSI_A_DISP 12'h018
`define MCSI_A_BASE 12'h01C

// ctrl register fields
`define MCSI_C_RESET 0
`define MCSI_C_SELFTEST 1
`define MCSI_C_CMD_START 2
`define MCSI_C_CMD_DONE 3
`define MCSI_C_CMD_ERR 4
`define MCSI_C_ERRNUM_LO 8
`define MCSI_C_ERRNUM_HI 15
`define MCSI_C_MODE_LO 16
`define MCSI_C_MODE_HI 22
`define MCSI_C_REQ_TRUE 24

// irq bits
`define MCSI_I_REQ 0
`define MCSI_I_FAIL 1
`define MCSI_I_DONE 2
`define MCSI_I_CMD 3
`define MCSI_I_W 4

// address decode
`define MCSI_DYN_LA 8'hFF
`define MCSI_BASE_OFS 24'h00C000
`define MCSI_BASE_SHIFT 6

// interrupt level switch
`define MCSI_LVL_MAX 4'h7

// memory depth in words
`define MCSI_DEPTH_256K 21'h040000
`define MCSI_DEPTH_512K 21'h080000
`define MCSI_DEPTH_1M 21'h100000
`define MCSI_STRAP_256K 2'h0
`define MCSI_STRAP_512K 2'h1
`define MCSI_STRAP_1M 2'h3

// display words, ascii
`define MCSI_TXT_BUSY 32'h42555359
`define MCSI_TXT_RDY 32'h52445920
`define MCSI_TXT_ERR 16'h452D
`define MCSI_ASCII_0 8'h30

// timing and display states
`define MCSI_CLK_HZ 20000000
`define MCSI_STRETCH_MS 200
`define MCSI_SELFTEST_CYC 16'h0100
`define MCSI_DISP_IDLE 2'h0
`define MCSI_DISP_BUSY 2'h1
`define MCSI_DISP_RDY 2'h2
`define MCSI_DISP_ERR 2'h3

`endif

// file: rtl/mcsi_stretch.v
// retriggerable down-counter that stretches short events for an indicator
`timescale 1ns/1ps
`include "mcsi_consts.vh"
module mcsi_stretch #(
    parameter [23:0] RELOAD = 24'h3D0900
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_hit,
    output reg o_lit
);
    reg [23:0] cnt_q;
    always @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= 24'h000000;
            o_lit <= 1'b0;
        end else begin
            if (i_hit) begin
                cnt_q <= RELOAD;
            end else if (cnt_q != 24'h000000) begin
                cnt_q <= cnt_q - 24'h000001;
            end
            o_lit <= i_hit || (cnt_q > 24'h000001);
        end
    end
endmodule

// file: rtl/mcsi_switch_decode.v
// decodes address, interrupt level and memory strap switches
`timescale 1ns/1ps
`include "mcsi_consts.vh"
module mcsi_switch_decode (
    input wire [3:0] i_upper_address_digit_switch,
    input wire [3:0] i_lower_address_digit_switch,
    input wire [3:0] i_irq_level_switch,
    input wire [1:0] i_memory_depth_strap,
    output wire o_dynamic,
    output wire [23:0] o_base_addr,
    output wire [2:0] o_irq_level,
    output wire o_irq_allowed,
    output reg [20:0] o_mem_depth
);
    wire [7:0] la = {i_upper_address_digit_switch,
        i_lower_address_digit_switch};
    assign o_dynamic = (la == `MCSI_DYN_LA);
    assign o_base_addr = ({16'h0000, la} << `MCSI_BASE_SHIFT)
        + `MCSI_BASE_OFS;
    assign o_irq_allowed = (i_irq_level_switch != 4'h0) &&
        (i_irq_level_switch <= `MCSI_LVL_MAX);
    assign o_irq_level = o_irq_allowed ? i_irq_level_switch[2:0] : 3'h0;
    always @* begin
        case (i_memory_depth_strap)
            `MCSI_STRAP_512K: o_mem_depth = `MCSI_DEPTH_512K;
            `MCSI_STRAP_1M: o_mem_depth = `MCSI_DEPTH_1M;
            default: o_mem_depth = `MCSI_DEPTH_256K;
        endcase
    end
endmodule

// file: rtl/mcsi_top.v
// configuration switches, status indicators and ahb-lite registers
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "mcsi_consts.vh"
module mcsi_top #(
    parameter [23:0] STRETCH_CYC = 24'h3D0900
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire [3:0] i_upper_address_digit_switch,
    input wire [3:0] i_lower_address_digit_switch,
    input wire [3:0] i_irq_level_switch,
    input wire i_halt_select_switch,
    input wire i_factory_boot_switch,
    input wire [1:0] i_memory_depth_strap,
    input wire i_backplane_access,
    input wire i_irq_ack,
    input wire i_rail_lost,
    input wire i_cpu_fault,
    input wire i_selftest_fail,
    input wire i_arm,
    input wire i_triggered,
    input wire i_sample_tick,
    input wire i_mem_full,
    input wire i_mem_access,
    input wire i_rearm,
    input wire i_gate_active,
    output reg o_irq,
    output reg [2:0] o_irq_level,
    output reg o_module_reset,
    output reg o_sysfail,
    output reg o_selftest_run,
    output reg o_bus_activity_indicator,
    output reg o_pending_request_indicator,
    output reg o_armed_indicator,
    output reg o_sample_clock_indicator,
    output reg o_sampling_active_indicator,
    output reg o_conversion_done_indicator,
    output reg o_failure_indicator,
    output reg o_triggered_indicator,
    output reg o_two_line_input_indicator,
    output reg o_fifty_ohm_load_indicator,
    output reg o_capacitive_coupling_indicator,
    output reg o_gate_indicator,
    output reg o_binary_mode_indicator,
    output reg o_aux_connector_source_indicator,
    output reg [31:0] o_error_code_display
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_TEST = 2'h1;
    localparam [1:0] ST_FAIL = 2'h2;

    function [7:0] bcd_digit;
        input [3:0] d;
        begin
            bcd_digit = `MCSI_ASCII_0 + {4'h0, d};
        end
    endfunction

    wire dyn_w;
    wire [23:0] base_w;
    wire [2:0] lvl_w;
    wire irq_ok_w;
    wire [20:0] depth_w;
    wire stretch_w;

    mcsi_switch_decode u_dec (
        .i_upper_address_digit_switch(i_upper_address_digit_switch),
        .i_lower_address_digit_switch(i_lower_address_digit_switch),
        .i_irq_level_switch(i_irq_level_switch),
        .i_memory_depth_strap(i_memory_depth_strap),
        .o_dynamic(dyn_w),
        .o_base_addr(base_w),
        .o_irq_level(lvl_w),
        .o_irq_allowed(irq_ok_w),
        .o_mem_depth(depth_w)
    );

    mcsi_stretch #(.RELOAD(STRETCH_CYC)) u_str (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_hit(i_backplane_access),
        .o_lit(stretch_w)
    );

    // ahb address phase capture
    reg ph_q;
    reg ph_wr_q;
    reg [11:0] ph_a_q;
    reg [31:0] mode_q;
    reg [7:0] errnum_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_en_q;
    reg [1:0] disp_q;
    reg [1:0] st_q;
    reg [15:0] tcnt_q;
    reg req_q;
    reg sampling_q;
    reg done_q;
    reg armed_q;
    reg fail_q;
    wire take = i_hsel && i_hready && i_htrans[1];
    wire wr_now = ph_q && ph_wr_q;
    wire [31:0] wd = i_hwdata;
    wire w_ctrl = wr_now && (ph_a_q == `MCSI_A_CTRL);
    wire w_clr = wr_now && (ph_a_q == `MCSI_A_IRQ_CLR);
    wire w_en = wr_now && (ph_a_q == `MCSI_A_IRQ_EN);
    wire halt_rst = w_ctrl && wd[`MCSI_C_RESET] && i_halt_select_switch;
    wire fail_now = i_selftest_fail || i_rail_lost || i_cpu_fault;
    wire cmd_start = w_ctrl && wd[`MCSI_C_CMD_START];
    wire cmd_done = w_ctrl && wd[`MCSI_C_CMD_DONE];
    wire req_set = w_ctrl && wd[`MCSI_C_REQ_TRUE];
    wire [3:0] ev;
    assign ev[`MCSI_I_REQ] = req_set;
    assign ev[`MCSI_I_FAIL] = fail_now && !fail_q;
    assign ev[`MCSI_I_DONE] = i_mem_full && sampling_q;
    assign ev[`MCSI_I_CMD] = cmd_done;

    always @(posedge i_clk) begin
        if (i_rst) begin
            ph_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_a_q <= 12'h000;
        end else begin
            ph_q <= take;
            ph_wr_q <= i_hwrite;
            ph_a_q <= i_haddr[11:0];
        end
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (take && !i_hwrite) begin
                case (i_haddr[11:0])
                    `MCSI_A_CFG: o_hrdata <= {8'h00, depth_w[20:0],
                        lvl_w};
                    `MCSI_A_CTRL: o_hrdata <= mode_q;
                    `MCSI_A_STAT: o_hrdata <= {20'h00000, irq_ok_w,
                        dyn_w, i_factory_boot_switch,
                        i_halt_select_switch, st_q, disp_q, fail_q,
                        armed_q, sampling_q, done_q};
                    `MCSI_A_IRQ_STAT: o_hrdata <= {28'h0000000,
                        irq_stat_q};
                    `MCSI_A_IRQ_EN: o_hrdata <= {28'h0000000, irq_en_q};
                    `MCSI_A_DISP: o_hrdata <= o_error_code_display;
                    `MCSI_A_BASE: o_hrdata <= {8'h00, base_w};
                    default: o_hrdata <= 32'h00000000;
                endcase
            end else begin
                o_hrdata <= 32'h00000000;
            end
        end
    end

    // control/mode register, error number, interrupt registers
    always @(posedge i_clk) begin
        if (i_rst || halt_rst) begin
            mode_q <= 32'h00000000;
            errnum_q <= 8'h00;
            irq_stat_q <= 4'h0;
            irq_en_q <= 4'h0;
        end else begin
            if (w_ctrl) begin
                mode_q <= {9'h000, wd[`MCSI_C_MODE_HI:`MCSI_C_MODE_LO],
                    16'h0000};
                errnum_q <= wd[`MCSI_C_ERRNUM_HI:`MCSI_C_ERRNUM_LO];
            end
            if (w_en) begin
                irq_en_q <= wd[3:0];
            end
            // set wins over clear
            irq_stat_q <= (irq_stat_q & ~(w_clr ? wd[3:0] : 4'h0)) | ev;
        end
    end

    // self test sequencer
    always @(posedge i_clk) begin
        if (i_rst || halt_rst) begin
            st_q <= ST_TEST;
            tcnt_q <= 16'h0000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    tcnt_q <= 16'h0000;
                    if (w_ctrl && wd[`MCSI_C_SELFTEST]) begin
                        st_q <= ST_TEST;
                    end
                end
                ST_TEST: begin
                    tcnt_q <= tcnt_q + 16'h0001;
                    if (i_selftest_fail) begin
                        st_q <= ST_FAIL;
                    end else if (tcnt_q == `MCSI_SELFTEST_CYC) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_FAIL: begin
                    if (w_ctrl && wd[`MCSI_C_SELFTEST]) begin
                        st_q <= ST_TEST;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // display state
    always @(posedge i_clk) begin
        if (i_rst || halt_rst) begin
            disp_q <= `MCSI_DISP_IDLE;
        end else if (cmd_start) begin
            disp_q <= `MCSI_DISP_BUSY;
        end else if (cmd_done) begin
            disp_q <= wd[`MCSI_C_CMD_ERR] ? `MCSI_DISP_ERR
                : `MCSI_DISP_RDY;
        end
    end

    // acquisition indicator state
    always @(posedge i_clk) begin
        if (i_rst || halt_rst) begin
            req_q <= 1'b0;
            sampling_q <= 1'b0;
            done_q <= 1'b1;
            armed_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            fail_q <= fail_now || (st_q == ST_FAIL);
            if (req_set && irq_ok_w) begin
                req_q <= 1'b1;
            end else if (i_irq_ack) begin
                req_q <= 1'b0;
            end
            if (i_arm) begin
                armed_q <= 1'b1;
            end else if (i_mem_full) begin
                armed_q <= 1'b0;
            end
            if (i_mem_full || i_mem_access || i_rearm) begin
                sampling_q <= 1'b0;
            end else if (i_triggered && armed_q) begin
                sampling_q <= 1'b1;
            end
            if (i_mem_full || i_mem_access) begin
                done_q <= 1'b1;
            end else if (i_arm) begin
                done_q <= 1'b0;
            end
        end
    end

    // registered outputs
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
            o_irq_level <= 3'h0;
            o_module_reset <= 1'b0;
            o_sysfail <= 1'b0;
            o_selftest_run <= 1'b0;
            o_bus_activity_indicator <= 1'b0;
            o_pending_request_indicator <= 1'b0;
            o_armed_indicator <= 1'b0;
            o_sample_clock_indicator <= 1'b0;
            o_sampling_active_indicator <= 1'b0;
            o_conversion_done_indicator <= 1'b0;
            o_failure_indicator <= 1'b0;
            o_triggered_indicator <= 1'b0;
            o_two_line_input_indicator <= 1'b0;
            o_fifty_ohm_load_indicator <= 1'b0;
            o_capacitive_coupling_indicator <= 1'b0;
            o_gate_indicator <= 1'b0;
            o_binary_mode_indicator <= 1'b0;
            o_aux_connector_source_indicator <= 1'b0;
            o_error_code_display <= 32'h00000000;
        end else begin
            o_irq <= irq_ok_w && |(irq_stat_q & irq_en_q);
            o_irq_level <= lvl_w;
            o_module_reset <= halt_rst;
            o_sysfail <= fail_q;
            o_failure_indicator <= fail_q;
            o_selftest_run <= (st_q == ST_TEST);
            o_bus_activity_indicator <= stretch_w;
            o_pending_request_indicator <= req_q;
            o_armed_indicator <= armed_q;
            if (i_sample_tick) begin
                o_sample_clock_indicator <= !o_sample_clock_indicator;
            end
            o_sampling_active_indicator <= sampling_q;
            o_conversion_done_indicator <= done_q;
            o_triggered_indicator <= i_triggered;
            o_two_line_input_indicator <= mode_q[16];
            o_fifty_ohm_load_indicator <= mode_q[17];
            o_capacitive_coupling_indicator <= mode_q[18];
            o_gate_indicator <= i_gate_active;
            o_binary_mode_indicator <= mode_q[20];
            o_aux_connector_source_indicator <= mode_q[21];
            case (disp_q)
                `MCSI_DISP_BUSY: o_error_code_display <= `MCSI_TXT_BUSY;
                `MCSI_DISP_RDY: o_error_code_display <= `MCSI_TXT_RDY;
                `MCSI_DISP_ERR: o_error_code_display <= {`MCSI_TXT_ERR,
                    bcd_digit(errnum_q[7:4]), bcd_digit(errnum_q[3:0])};
                default: o_error_code_display <= 32'h00000000;
            endcase
        end
    end
endmodule

// file: testbench/mcsi_commander.sv
// behavioural backplane commander that services request interrupts
`timescale 1ns/1ps
module mcsi_commander (
    input wire i_clk,
    input wire i_pending,
    input wire [7:0] i_delay,
    output reg o_ack
);
    reg [7:0] cnt_q = 8'h00;
    initial o_ack = 1'b0;
    // one-cycle acknowledge once a request has waited i_delay cycles
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        if (!i_pending || o_ack) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= i_delay) begin
            o_ack <= 1'b1;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// file: testbench/mcsi_top_chk.sv
// concurrent checks on the configuration and status block ports
`timescale 1ns/1ps
module mcsi_top_chk #(
    parameter [23:0] STRETCH_CYC = 24'h3D0900
) (
    input wire i_clk,
    input wire i_rst,
    input wire [3:0] i_irq_level_switch,
    input wire i_halt_select_switch,
    input wire i_backplane_access,
    input wire i_irq_ack,
    input wire i_rail_lost,
    input wire i_cpu_fault,
    input wire i_triggered,
    input wire i_sample_tick,
    input wire o_irq,
    input wire [2:0] o_irq_level,
    input wire o_module_reset,
    input wire o_sysfail,
    input wire o_failure_indicator,
    input wire o_bus_activity_indicator,
    input wire o_pending_request_indicator,
    input wire o_sample_clock_indicator,
    input wire o_triggered_indicator
);
    reg [7:0] idle_q;
    wire lvl_ok;
    wire fault;
    assign lvl_ok = i_irq_level_switch >= 4'h1 &&
        i_irq_level_switch <= 4'h7;
    assign fault = i_rail_lost | i_cpu_fault;
    // cycles since the last backplane access, saturating
    always @(posedge i_clk) begin
        if (i_rst || i_backplane_access) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'hFF) begin
            idle_q <= idle_q + 8'h01;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    chk_level_map: assert property (
        lvl_ok |=> o_irq_level == $past(i_irq_level_switch[2:0]))
        else $error("irq level does not follow switch");
    chk_level_mute: assert property (
        !lvl_ok ##1 !lvl_ok |=> o_irq_level == 3'h0 && !o_irq)
        else $error("interrupt not suppressed");
    chk_halt_gate: assert property (
        o_module_reset |-> $past(i_halt_select_switch))
        else $error("module reset with halt off");
    chk_fail_raise: assert property (
        fault ##1 fault |=> o_sysfail && o_failure_indicator)
        else $error("failure not signalled");
    chk_stretch_on: assert property (
        $rose(i_backplane_access) |=> ##1 o_bus_activity_indicator [*8])
        else $error("activity indicator not stretched");
    chk_stretch_off: assert property (
        idle_q > STRETCH_CYC + 24'h3 |-> !o_bus_activity_indicator)
        else $error("activity indicator stuck on");
    chk_pend_clear: assert property (
        i_irq_ack |=> ##1 !o_pending_request_indicator)
        else $error("request indicator not cleared");
    chk_tick_toggle: assert property (
        $past(i_sample_tick) |->
        o_sample_clock_indicator != $past(o_sample_clock_indicator))
        else $error("sample clock indicator did not toggle");
    chk_trig_follow: assert property (
        o_triggered_indicator == $past(i_triggered))
        else $error("triggered indicator wrong");
    cov_halt_reset: cover property (o_module_reset);
    cov_irq_raise: cover property ($rose(o_irq));
    cov_fail: cover property ($rose(o_sysfail));
endmodule
bind mcsi_top mcsi_top_chk #(.STRETCH_CYC(STRETCH_CYC)) u_chk (.*);

// file: testbench/mcsi_top_tb.sv
// self-checking bench for the configuration and status block
`timescale 1ns/1ps
`include "mcsi_consts.vh"
module mcsi_top_tb;
    reg i_clk = 1'b0;
    reg i_rst = 1'b1;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0;
    reg [31:0] hwdata = 32'h0;
    reg [7:0] adr_sw = 8'h12;
    reg [3:0] lvl = 4'h3;
    reg [1:0] strap = 2'h0;
    reg [6:0] lv = 7'h0;
    reg [5:0] ev = 6'h0;
    reg [7:0] dly = 8'h0A;
    reg [31:0] d;
    reg [20:0] dp;
    reg ok;
    wire [31:0] rdata;
    wire [31:0] disp;
    wire [4:0] mode_led;
    wire rdy, ack, pend, irq, sysf, fail_led, st_run, bus_led, mrst;
    wire armed, clk_led, samp, done, gate_led, trg_led;
    integer err_count = 0;
    integer check_count = 0;
    integer cyc_n = 0;
    integer mrst_cnt = 0;
    integer i;
    always #25 i_clk = ~i_clk;
    mcsi_top #(.STRETCH_CYC(24'h000014)) DUT (
        .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(rdata),
        .o_hreadyout(rdy), .o_hresp(),
        .i_upper_address_digit_switch(adr_sw[7:4]),
        .i_lower_address_digit_switch(adr_sw[3:0]),
        .i_irq_level_switch(lvl), .i_halt_select_switch(lv[5]),
        .i_factory_boot_switch(lv[6]), .i_memory_depth_strap(strap),
        .i_backplane_access(ev[5]), .i_irq_ack(ack),
        .i_rail_lost(lv[2]), .i_cpu_fault(lv[3]),
        .i_selftest_fail(lv[4]), .i_arm(ev[0]), .i_triggered(lv[0]),
        .i_sample_tick(ev[1]), .i_mem_full(ev[2]), .i_mem_access(ev[3]),
        .i_rearm(ev[4]), .i_gate_active(lv[1]), .o_irq(irq),
        .o_irq_level(), .o_module_reset(mrst), .o_sysfail(sysf),
        .o_selftest_run(st_run), .o_bus_activity_indicator(bus_led),
        .o_pending_request_indicator(pend), .o_armed_indicator(armed),
        .o_sample_clock_indicator(clk_led),
        .o_sampling_active_indicator(samp),
        .o_conversion_done_indicator(done), .o_failure_indicator(fail_led),
        .o_triggered_indicator(trg_led),
        .o_two_line_input_indicator(mode_led[0]),
        .o_fifty_ohm_load_indicator(mode_led[1]),
        .o_capacitive_coupling_indicator(mode_led[2]),
        .o_gate_indicator(gate_led), .o_binary_mode_indicator(mode_led[3]),
        .o_aux_connector_source_indicator(mode_led[4]),
        .o_error_code_display(disp)
    );
    mcsi_commander u_cmdr (.i_clk(i_clk), .i_pending(pend), .i_delay(dly),
        .o_ack(ack));
    task cyc(input integer n);
        repeat (n) @(posedge i_clk);
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("unexpected %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task flg(input got, input exp);
        cmp({31'h0, got}, {31'h0, exp});
    endtask
    // one single-word transfer; address held until hready, then data
    task xfer(input w, input [31:0] a, input [31:0] wd);
        begin
            @(posedge i_clk);
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= w;
            do @(posedge i_clk); while (rdy !== 1'b1);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            do @(posedge i_clk); while (rdy !== 1'b1);
            d = rdata;
        end
    endtask
    task wr(input [31:0] a, input [31:0] v);
        begin
            xfer(1'b1, a, v);
            cyc(2);
        end
    endtask
    task rc(input [31:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0);
            cmp(d, exp);
        end
    endtask
    task pulse(input integer b);
        begin
            @(posedge i_clk);
            ev[b] <= 1'b1;
            @(posedge i_clk);
            ev[b] <= 1'b0;
        end
    endtask
    task setlv(input integer b, input v);
        begin
            @(posedge i_clk);
            lv[b] <= v;
            cyc(2);
        end
    endtask
    task results;
        begin
            $display("checks %0d errors %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    always @(posedge i_clk) begin
        cyc_n = cyc_n + 1;
        if (mrst === 1'b1) begin
            mrst_cnt = mrst_cnt + 1;
        end
        if (cyc_n == 20000) begin
            err_count = err_count + 1;
            results;
        end
    end
    initial begin
        cyc(16);
        i_rst <= 1'b0;
        cyc(3);
        flg(st_run, 1'b1);
        flg(done, 1'b1);
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge i_clk) adr_sw <= (i == 0) ? 8'h12 : 8'hFD + i[7:0];
            cyc(2);
            rc(`MCSI_A_BASE, 32'hC000 + {adr_sw, 6'h0});
            xfer(1'b0, `MCSI_A_STAT, 32'h0);
            flg(d[10], adr_sw == 8'hFF);
            flg(d[8], 1'b0);
        end
        for (i = 0; i < 10; i = i + 1) begin
            @(posedge i_clk) lvl <= i[3:0];
            cyc(2);
            ok = i >= 1 && i <= 7;
            rc(`MCSI_A_CFG, {21'h040000, ok ? i[2:0] : 3'h0});
            xfer(1'b0, `MCSI_A_STAT, 32'h0);
            flg(d[11], ok);
            flg(d[10], 1'b1);
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge i_clk) strap <= i[1:0];
            cyc(2);
            dp = (i == 1) ? 21'h080000 : 21'h040000;
            if (i == 3) dp = 21'h100000;
            rc(`MCSI_A_CFG, {dp, 3'h0});
        end
        @(posedge i_clk) lvl <= 4'h3;
        wr(`MCSI_A_CTRL, 32'h4);
        rc(`MCSI_A_DISP, 32'h42555359);
        wr(`MCSI_A_CTRL, 32'h8);
        rc(`MCSI_A_DISP, 32'h52445920);
        wr(`MCSI_A_CTRL, 32'h4218);
        rc(`MCSI_A_DISP, 32'h452D3432);
        cmp(disp, 32'h452D3432);
        wr(`MCSI_A_IRQ_CLR, 32'hF);
        rc(`MCSI_A_IRQ_STAT, 32'h0);
        wr(`MCSI_A_IRQ_EN, 32'h8);
        flg(irq, 1'b0);
        wr(`MCSI_A_CTRL, 32'h8);
        cyc(1);
        flg(irq, 1'b1);
        wr(`MCSI_A_IRQ_EN, 32'h0);
        cyc(1);
        flg(irq, 1'b0);
        rc(`MCSI_A_IRQ_STAT, 32'h8);
        wr(`MCSI_A_IRQ_EN, 32'h8);
        @(posedge i_clk) lvl <= 4'h0;
        cyc(3);
        flg(irq, 1'b0);
        wr(`MCSI_A_CTRL, 32'h01000000);
        flg(pend, 1'b0);
        @(posedge i_clk) lvl <= 4'h3;
        cyc(3);
        flg(irq, 1'b1);
        wr(`MCSI_A_IRQ_CLR, 32'h8);
        cyc(1);
        flg(irq, 1'b0);
        rc(`MCSI_A_IRQ_EN, 32'h8);
        wr(`MCSI_A_CTRL, 32'h01000000);
        flg(pend, 1'b1);
        rc(`MCSI_A_IRQ_STAT, 32'h1);
        cyc(20);
        flg(pend, 1'b0);
        wr(`MCSI_A_CTRL, 32'h00370000);
        cmp(mode_led, 32'h1F);
        rc(`MCSI_A_CTRL, 32'h00370000);
        wr(`MCSI_A_CTRL, 32'h00120000);
        cmp(mode_led, 32'h0A);
        setlv(1, 1'b1);
        flg(gate_led, 1'b1);
        for (i = 2; i < 5; i = i + 1) begin
            pulse(0);
            setlv(0, 1'b1);
            cyc(1);
            flg(armed, 1'b1);
            flg(samp, 1'b1);
            flg(trg_led, 1'b1);
            pulse(1);
            cyc(1);
            flg(clk_led, 1'b1);
            pulse(1);
            cyc(1);
            flg(clk_led, 1'b0);
            setlv(0, 1'b0);
            pulse(i);
            cyc(2);
            flg(samp, 1'b0);
            if (i == 2) flg(armed, 1'b0);
            if (i < 4) flg(done, 1'b1);
        end
        pulse(5);
        cyc(2);
        flg(bus_led, 1'b1);
        cyc(30);
        flg(bus_led, 1'b0);
        @(posedge i_clk) ev[5] <= 1'b1;
        cyc(60);
        flg(bus_led, 1'b1);
        @(posedge i_clk) ev[5] <= 1'b0;
        for (i = 2; i < 4; i = i + 1) begin
            setlv(i, 1'b1);
            cyc(2);
            flg(sysf, 1'b1);
            flg(fail_led, 1'b1);
            setlv(i, 1'b0);
        end
        rc(`MCSI_A_IRQ_STAT, 32'h7);
        flg(d[1], 1'b1);
        wr(`MCSI_A_CTRL, 32'h1);
        cyc(3);
        cmp(mrst_cnt, 32'h0);
        flg(st_run, 1'b0);
        setlv(5, 1'b1);
        wr(`MCSI_A_CTRL, 32'h1);
        cyc(3);
        cmp(mrst_cnt, 32'h1);
        flg(st_run, 1'b1);
        setlv(4, 1'b1);
        cyc(300);
        flg(st_run, 1'b0);
        flg(sysf, 1'b1);
        xfer(1'b0, `MCSI_A_STAT, 32'h0);
        cmp(d[7:6], 32'h2);
        flg(d[3], 1'b1);
        setlv(4, 1'b0);
        wr(32'h40, 32'hFFFFFFFF);
        rc(32'h40, 32'h0);
        results;
    end
endmodule
